//--- rtl/bflp_pkg.sv
// Constants, types and helpers shared by the boot flash protection block.
package bflp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PTR = 8'h00;
  localparam logic [7:0] OFS_LOCKS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_LATCH = 8'h0c;
  localparam logic [7:0] OFS_RVEC = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Lock field layout and reset values
  // ----------------------------------------------------------------
  localparam int LK_GEN_LO = 0;
  localparam int LK_GEN_HI = 1;
  localparam int LK_APP_LO = 2;
  localparam int LK_APP_HI = 3;
  localparam int LK_BOOT_LO = 4;
  localparam int LK_BOOT_HI = 5;
  localparam logic [5:0] LOCK_RST = 6'h3f;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] DENIED_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------
  localparam int PAGE_WORD_BITS = 6;
  localparam logic [14:0] BOOT_START_WORD = 15'h7800;
  localparam logic [14:0] APP_RESET_WORD = 15'h0000;

  typedef enum logic [1:0] {
    OP_FILL = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_SETLOCK = 2'h3
  } bflp_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_WAIT = 2'h2
  } bflp_state_type;

  function automatic logic bflp_in_boot(input logic [14:0] word_addr);
    return word_addr >= BOOT_START_WORD;
  endfunction : bflp_in_boot

endpackage : bflp_pkg

//--- rtl/bflp_top.sv
// Boot flash protection: lock checks, pointer decode and reset vector selection.
//
// Summary of operation
// - Locks only programmed; chip erase restores them.
// - General write lock never blocks store-program.
// - General read/write lock never blocks load/store.
// - Application mode 1: no access restriction.
// - Application mode 2: writes blocked, reads allowed.
// - Application mode 3: writes and boot reads blocked.
// - Application mode 4: boot reads blocked, writes allowed.
// - Application modes 3/4: mask interrupts in application.
// - Boot mode 1: no access restriction.
// - Boot mode 2: writes blocked, reads allowed.
// - Boot mode 3: writes and application reads blocked.
// - Boot mode 4: application reads blocked, writes allowed.
// - Boot modes 3/4: mask interrupts in boot.
// - Fuse unprogrammed: reset vector is word zero.
// - Fuse programmed: reset vector is boot start.
// - Software can never alter any fuse.
// - Store address comes from sixteen-bit pointer.
// - Address splits into page and word fields.
// - Address latched when an operation starts.
// - Lock setting ignores the pointer entirely.
// - Load reads bytewise, pointer bit zero selects.
// - Store-program only acts from boot section.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module bflp_top
  import bflp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [14:0] cpu_pc,
  input wire logic vectors_in_boot,
  input wire logic spm_go,
  input wire logic [1:0] spm_op,
  input wire logic [7:0] spm_r0,
  input wire logic lpm_go,
  input wire logic flash_ack,
  input wire logic [15:0] flash_rdata,
  input wire logic boot_reset_fuse,
  input wire logic chip_erase,
  input wire logic ext_lock_strobe,
  input wire logic [5:0] ext_lock_data,
  output logic flash_req,
  output logic [1:0] flash_op,
  output logic [8:0] page_index_field,
  output logic [5:0] word_index_field,
  output logic flash_rd,
  output logic [14:0] flash_raddr,
  output logic spm_done,
  output logic spm_denied,
  output logic lpm_valid,
  output logic [7:0] lpm_data,
  output logic lpm_denied,
  output logic irq_block,
  output logic [14:0] reset_vector,
  output logic [5:0] lock_bits
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] sync_a_r;
  logic [8:0] sync_b_r;
  logic strobe_d_r;
  logic fuse_s;
  logic erase_s;
  logic strobe_s;
  logic [5:0] ext_data_s;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // The fuse stage resets to its unprogrammed level, so no boot vector flashes out after reset.
      sync_a_r <= 9'h001;
      sync_b_r <= 9'h001;
      strobe_d_r <= 1'b0;
    end else begin
      sync_a_r <= {ext_lock_data, ext_lock_strobe, chip_erase, boot_reset_fuse};
      sync_b_r <= sync_a_r;
      strobe_d_r <= sync_b_r[2];
    end
  end

  assign fuse_s = sync_b_r[0];
  assign erase_s = sync_b_r[1];
  assign strobe_s = sync_b_r[2] && !strobe_d_r;
  assign ext_data_s = sync_b_r[8:3];

  // ----------------------------------------------------------------
  // Access decisions
  // ----------------------------------------------------------------
  logic [5:0] locks_r;
  logic [5:0] locks_nxt;
  logic [15:0] ptr_r;
  logic [15:0] ptr_nxt;
  logic [14:0] z_word;
  logic pc_boot;
  logic tgt_boot;
  logic wr_ok;
  logic rd_ok;

  // The general lock bits are stored but deliberately never consulted here.
  assign z_word = ptr_r[15:1];
  assign pc_boot = bflp_in_boot(cpu_pc);
  assign tgt_boot = bflp_in_boot(z_word);
  // Upper lock bit guards cross-section reads, lower bit guards writes.
  assign wr_ok = tgt_boot ? locks_r[LK_BOOT_LO] : locks_r[LK_APP_LO];
  assign rd_ok = tgt_boot ? (pc_boot || locks_r[LK_BOOT_HI])
               : (!pc_boot || locks_r[LK_APP_HI]);

  // ----------------------------------------------------------------
  // Store-program sequencing
  // ----------------------------------------------------------------
  bflp_state_type st_r;
  bflp_state_type st_nxt;
  logic flash_req_nxt;
  logic [1:0] flash_op_nxt;
  logic [8:0] page_nxt;
  logic [5:0] word_nxt;
  logic spm_done_nxt;
  logic spm_denied_nxt;
  logic [5:0] lock_and;

  always_comb begin
    st_nxt = st_r;
    flash_req_nxt = 1'b0;
    flash_op_nxt = flash_op;
    page_nxt = page_index_field;
    word_nxt = word_index_field;
    spm_done_nxt = 1'b0;
    spm_denied_nxt = spm_denied;
    lock_and = LOCK_RST;
    case (st_r)
      ST_IDLE: begin
        if (spm_go) begin
          if (!pc_boot) begin
            spm_done_nxt = 1'b1;
            spm_denied_nxt = 1'b1;
          end else if (spm_op == OP_SETLOCK) begin
            lock_and = spm_r0[5:0];
            spm_done_nxt = 1'b1;
            spm_denied_nxt = 1'b0;
          end else begin
            page_nxt = z_word[14:PAGE_WORD_BITS];
            word_nxt = z_word[PAGE_WORD_BITS-1:0];
            flash_op_nxt = spm_op;
            if (spm_op == OP_FILL || wr_ok) begin
              flash_req_nxt = 1'b1;
              spm_denied_nxt = 1'b0;
              st_nxt = ST_WAIT;
            end else begin
              spm_done_nxt = 1'b1;
              spm_denied_nxt = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        if (flash_ack) begin
          spm_done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      flash_req <= 1'b0;
      flash_op <= 2'h0;
      page_index_field <= '0;
      word_index_field <= '0;
      spm_done <= 1'b0;
      spm_denied <= 1'b0;
    end else begin
      st_r <= st_nxt;
      flash_req <= flash_req_nxt;
      flash_op <= flash_op_nxt;
      page_index_field <= page_nxt;
      word_index_field <= word_nxt;
      spm_done <= spm_done_nxt;
      spm_denied <= spm_denied_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Lock bits, interrupt masking and reset vector
  // ----------------------------------------------------------------
  logic irq_nxt;
  logic [14:0] rvec_nxt;

  always_comb begin
    // Bits only ever move towards programmed; erase and reset are the only ways back.
    locks_nxt = locks_r & lock_and;
    if (strobe_s) begin
      locks_nxt = locks_nxt & ext_data_s;
    end
    if (erase_s) begin
      locks_nxt = LOCK_RST;
    end
    irq_nxt = (!locks_r[LK_APP_HI] && vectors_in_boot && !pc_boot)
           || (!locks_r[LK_BOOT_HI] && !vectors_in_boot && pc_boot);
    // The fuse has no write path from software at all.
    rvec_nxt = fuse_s ? APP_RESET_WORD : BOOT_START_WORD;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      locks_r <= LOCK_RST;
      irq_block <= 1'b0;
      reset_vector <= APP_RESET_WORD;
    end else begin
      locks_r <= locks_nxt;
      irq_block <= irq_nxt;
      reset_vector <= rvec_nxt;
    end
  end

  assign lock_bits = locks_r;

  // ----------------------------------------------------------------
  // Load-program reads
  // ----------------------------------------------------------------
  logic rd_wait_r;
  logic byte_sel_r;
  logic flash_rd_nxt;
  logic [14:0] raddr_nxt;
  logic byte_sel_nxt;
  logic lpm_valid_nxt;
  logic [7:0] lpm_data_nxt;
  logic lpm_denied_nxt;

  always_comb begin
    flash_rd_nxt = 1'b0;
    raddr_nxt = flash_raddr;
    byte_sel_nxt = byte_sel_r;
    lpm_valid_nxt = 1'b0;
    lpm_data_nxt = lpm_data;
    lpm_denied_nxt = lpm_denied;
    if (lpm_go && !flash_rd && !rd_wait_r) begin
      if (rd_ok) begin
        flash_rd_nxt = 1'b1;
        raddr_nxt = z_word;
        byte_sel_nxt = ptr_r[0];
        lpm_denied_nxt = 1'b0;
      end else begin
        lpm_valid_nxt = 1'b1;
        lpm_data_nxt = DENIED_BYTE;
        lpm_denied_nxt = 1'b1;
      end
    end
    if (rd_wait_r) begin
      lpm_valid_nxt = 1'b1;
      lpm_data_nxt = byte_sel_r ? flash_rdata[15:8] : flash_rdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flash_rd <= 1'b0;
      rd_wait_r <= 1'b0;
      flash_raddr <= '0;
      byte_sel_r <= 1'b0;
      lpm_valid <= 1'b0;
      lpm_data <= '0;
      lpm_denied <= 1'b0;
    end else begin
      flash_rd <= flash_rd_nxt;
      rd_wait_r <= flash_rd;
      flash_raddr <= raddr_nxt;
      byte_sel_r <= byte_sel_nxt;
      lpm_valid <= lpm_valid_nxt;
      lpm_data <= lpm_data_nxt;
      lpm_denied <= lpm_denied_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_hold_nxt;
  logic w_hold_nxt;
  logic [7:0] awaddr_nxt;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_nxt;
  logic bvalid_nxt;
  logic [1:0] bresp_nxt;
  logic rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  assign awready = !aw_hold_r && !bvalid;
  assign wready = !w_hold_r && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    aw_hold_nxt = aw_hold_r || (awvalid && awready);
    w_hold_nxt = w_hold_r || (wvalid && wready);
    awaddr_nxt = aw_hold_r ? awaddr_r : awaddr;
    wdata_nxt = w_hold_r ? wdata_r : wdata;
    wstrb_nxt = w_hold_r ? wstrb_r : wstrb;
    bvalid_nxt = bvalid && !bready;
    bresp_nxt = bresp;
    ptr_nxt = ptr_r;
    if (aw_hold_nxt && w_hold_nxt && !bvalid) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (awaddr_nxt)
        OFS_PTR: begin
          if (wstrb_nxt[0]) begin
            ptr_nxt[7:0] = wdata_nxt[7:0];
          end
          if (wstrb_nxt[1]) begin
            ptr_nxt[15:8] = wdata_nxt[15:8];
          end
        end
        OFS_LOCKS, OFS_STATUS, OFS_LATCH, OFS_RVEC: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    rvalid_nxt = rvalid && !rready;
    rdata_nxt = rdata;
    rresp_nxt = rresp;
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (araddr)
        OFS_PTR: rdata_nxt = {16'h0000, ptr_r};
        OFS_LOCKS: rdata_nxt = {26'h0000000, locks_r};
        OFS_STATUS: rdata_nxt = {24'h000000, 1'b0, lpm_denied, spm_denied,
                                  fuse_s, irq_block, pc_boot, tgt_boot, st_r == ST_WAIT};
        OFS_LATCH: rdata_nxt = {17'h00000, page_index_field, word_index_field};
        OFS_RVEC: rdata_nxt = {17'h00000, reset_vector};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      ptr_r <= PTR_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid <= bvalid_nxt;
      bresp <= bresp_nxt;
      rvalid <= rvalid_nxt;
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_spm_from_app: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r == ST_IDLE && spm_go && !pc_boot |=> spm_done && spm_denied && !flash_req)
    else $error("store-program from application was not refused");

  a_write_lock: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r == ST_IDLE && spm_go && pc_boot && spm_op == OP_ERASE
    && !(tgt_boot ? locks_r[LK_BOOT_LO] : locks_r[LK_APP_LO]) |=> !flash_req && spm_denied)
    else $error("locked section received an erase");

  a_gen_lock_free: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r == ST_IDLE && spm_go && pc_boot && spm_op == OP_WRITE && !tgt_boot
    && locks_r[LK_APP_LO] && !locks_r[LK_GEN_LO] |=> flash_req)
    else $error("general lock blocked a permitted write");

  a_app_read_lock: assert property (@(posedge mclk) disable iff (!arst_n)
    lpm_go && !flash_rd && !rd_wait_r && pc_boot && !tgt_boot && !locks_r[LK_APP_HI]
    |=> lpm_valid && lpm_denied && !flash_rd)
    else $error("boot code read a protected application byte");

  a_boot_read_lock: assert property (@(posedge mclk) disable iff (!arst_n)
    lpm_go && !flash_rd && !rd_wait_r && !pc_boot && tgt_boot && !locks_r[LK_BOOT_HI]
    |=> lpm_valid && lpm_denied && !flash_rd)
    else $error("application code read a protected boot byte");

  a_read_path: assert property (@(posedge mclk) disable iff (!arst_n)
    lpm_go && !flash_rd && !rd_wait_r && rd_ok
    |=> flash_rd ##1 !lpm_valid ##1 lpm_valid && !lpm_denied)
    else $error("granted read did not complete in three cycles");

  a_lock_monotone: assert property (@(posedge mclk) disable iff (!arst_n)
    !erase_s |=> (locks_r & ~$past(locks_r)) == 6'h00)
    else $error("lock bit returned to unprogrammed without erase");

  a_setlock_z_free: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r == ST_IDLE && spm_go && pc_boot && spm_op == OP_SETLOCK && !erase_s && !strobe_s
    |=> locks_r == ($past(locks_r) & $past(spm_r0[5:0])) && $stable(page_index_field))
    else $error("lock setting did not follow the data byte");

  a_latch_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    st_r == ST_WAIT |=> $stable(page_index_field) && $stable(word_index_field))
    else $error("latched address moved during an operation");

  a_irq_mask: assert property (@(posedge mclk) disable iff (!arst_n)
    !locks_r[LK_APP_HI] && vectors_in_boot && !pc_boot |=> irq_block)
    else $error("interrupts not masked in application section");

  a_reset_vector: assert property (@(posedge mclk) disable iff (!arst_n)
    !fuse_s |=> reset_vector == BOOT_START_WORD)
    else $error("programmed fuse did not select the boot vector");

endmodule : bflp_top

//--- bench/bflp_flash_model.sv
// Flash array stand-in that answers grant pulses and word reads.
module bflp_flash_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] ack_delay,
  input wire logic flash_req,
  input wire logic flash_rd,
  input wire logic [14:0] flash_raddr,
  output logic flash_ack,
  output logic [15:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  // Contents are a fixed function of the word address, so every byte read is predictable.
  function automatic logic [15:0] bflp_word(input logic [14:0] a);
    return {1'h1, a} ^ 16'h3c5a;
  endfunction : bflp_word

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      flash_ack <= 1'h0;
      flash_rdata <= 16'h0000;
    end else begin
      flash_ack <= 1'h0;
      if (flash_req) begin
        cnt <= int'(ack_delay);
      end else if (cnt == 1) begin
        flash_ack <= 1'h1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      // The word is valid for one cycle only; afterwards it toggles so stale data is never read.
      if (flash_rd) begin
        flash_rdata <= bflp_word(flash_raddr);
      end else begin
        flash_rdata <= ~flash_rdata;
      end
    end
  end
endmodule : bflp_flash_model

//--- bench/testbench.sv
// Self-checking bench for the boot flash protection block.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bflp_pkg::*;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, spm_r0 = 8'hff, ack_delay = 8'h02;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, flash_ack, flash_req, flash_rd;
  logic [1:0] bresp, rresp, flash_op, spm_op = 2'h0;
  logic [14:0] cpu_pc = 15'h7900, flash_raddr, reset_vector;
  logic vectors_in_boot = 1'h0, spm_go = 1'h0, lpm_go = 1'h0, boot_reset_fuse = 1'h1;
  logic chip_erase = 1'h0, ext_lock_strobe = 1'h0;
  logic [5:0] ext_lock_data = 6'h3f, word_index_field, lock_bits;
  logic spm_done, spm_denied, lpm_valid, lpm_denied, irq_block;
  logic [15:0] flash_rdata, cur_ptr = 16'h0;
  logic [8:0] page_index_field;
  logic [7:0] lpm_data;
  int n_fail = 0, samples_checked = 0, seed = 98734;
  logic [31:0] spm_q[$], lpm_q[$], adr_q[$];

  always #2.5 mclk = ~mclk;

  bflp_top u_bflp_top (.mclk(mclk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cpu_pc(cpu_pc), .vectors_in_boot(vectors_in_boot), .spm_go(spm_go),
    .spm_op(spm_op), .spm_r0(spm_r0), .lpm_go(lpm_go), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
    .boot_reset_fuse(boot_reset_fuse), .chip_erase(chip_erase), .ext_lock_strobe(ext_lock_strobe),
    .ext_lock_data(ext_lock_data), .flash_req(flash_req), .flash_op(flash_op),
    .page_index_field(page_index_field), .word_index_field(word_index_field), .flash_rd(flash_rd),
    .flash_raddr(flash_raddr), .spm_done(spm_done), .spm_denied(spm_denied), .lpm_valid(lpm_valid),
    .lpm_data(lpm_data), .lpm_denied(lpm_denied), .irq_block(irq_block), .reset_vector(reset_vector),
    .lock_bits(lock_bits));
  bflp_flash_model u_bflp_flash_model (.mclk(mclk), .arst_n(arst_n), .ack_delay(ack_delay),
    .flash_req(flash_req), .flash_rd(flash_rd), .flash_raddr(flash_raddr), .flash_ack(flash_ack),
    .flash_rdata(flash_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stall();
    n_fail++;
    $display("timeout at %0t", $time);
    finish_test();
  endtask : stall

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    logic aw, w, done;
    n = 0;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(negedge mclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      n++;
      if (n > 50) stall();
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, done;
    n = 0;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(negedge mclk);
      ar = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 1'h0;
      n++;
      if (n > 50) stall();
    end
  endtask : axi_read

  task automatic set_ptr(input logic [15:0] p);
    logic [1:0] r;
    axi_write(OFS_PTR, {16'h0, p}, 4'h3, r);
    check(32'(r), 32'(RESP_OKAY));
    cur_ptr = p;
  endtask : set_ptr

  // Each request notes its expected result, then waits until the monitor has consumed it.
  task automatic store_program_op(input logic [1:0] op, input logic den);
    int n;
    n = 0;
    spm_q.push_back(32'(den));
    if (!den && op != OP_SETLOCK) adr_q.push_back({15'h0, op, cur_ptr[15:7], cur_ptr[6:1]});
    spm_op <= op;
    spm_go <= 1'h1;
    @(posedge mclk);
    spm_go <= 1'h0;
    while (spm_q.size() > 0) begin
      @(posedge mclk);
      n++;
      if (n > 100) stall();
    end
  endtask : store_program_op

  task automatic lpm(input logic den);
    int n;
    logic [15:0] w;
    n = 0;
    w = {1'h1, cur_ptr[15:1]} ^ 16'h3c5a;
    lpm_q.push_back({23'h0, den, den ? DENIED_BYTE : (cur_ptr[0] ? w[15:8] : w[7:0])});
    lpm_go <= 1'h1;
    @(posedge mclk);
    lpm_go <= 1'h0;
    while (lpm_q.size() > 0) begin
      @(posedge mclk);
      n++;
      if (n > 20) stall();
    end
  endtask : lpm

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    if (spm_done === 1'h1) begin
      if (spm_q.size() == 0) check(32'h1, 32'h0);
      else check(32'(spm_denied), spm_q.pop_front());
    end
    if (lpm_valid === 1'h1) begin
      if (lpm_q.size() == 0) check(32'h1, 32'h0);
      else check({23'h0, lpm_denied, lpm_data}, lpm_q.pop_front());
    end
    if (flash_req === 1'h1) begin
      if (adr_q.size() == 0) check(32'h1, 32'h0);
      else check({15'h0, flash_op, page_index_field, word_index_field}, adr_q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [1:0] tbl[4];
    logic [1:0] bits;
    logic [7:0] r0;
    logic [14:0] own, oth;
    tbl = '{2'h3, 2'h2, 2'h0, 2'h1};
    tick(10);
    arst_n <= 1'h1;
    tick(1);
    @(negedge mclk);
    check(32'(reset_vector), 32'(APP_RESET_WORD));
    tick(3);
    check(32'(reset_vector), 32'(APP_RESET_WORD));
    check(32'(lock_bits), 32'(LOCK_RST));
    set_ptr(16'h1234);
    axi_write(OFS_PTR, 32'hffff5678, 4'h1, r);
    axi_read(OFS_PTR, d, r);
    check(d, 32'h00001278);
    axi_write(8'h40, 32'h1, 4'hf, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_read(8'h40, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_write(OFS_RVEC, 32'h7800, 4'hf, r);
    axi_read(OFS_RVEC, d, r);
    check(d, 32'(APP_RESET_WORD));
    $display("test register port done");
    cpu_pc <= 15'h0100;
    store_program_op(OP_ERASE, 1'h1);
    cpu_pc <= 15'h7900;
    ext_lock_data <= 6'h3e;
    ext_lock_strobe <= 1'h1;
    tick(4);
    ext_lock_strobe <= 1'h0;
    tick(3);
    check(32'(lock_bits), 32'h3e);
    // A slow flash lets the pointer move while the operation is still running.
    set_ptr(16'hf0c2);
    ack_delay <= 8'h14;
    fork
      store_program_op(OP_ERASE, 1'h0);
      begin
        tick(2);
        set_ptr(16'h1234);
      end
    join
    ack_delay <= 8'h01;
    axi_read(OFS_LATCH, d, r);
    check(d, {17'h0, 9'h1e1, 6'h21});
    $display("test address latch done");
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        bits = tbl[k];
        own = (s == 1) ? 15'h7900 : 15'h0100;
        oth = (s == 1) ? 15'h0100 : 15'h7900;
        chip_erase <= 1'h1;
        tick(4);
        chip_erase <= 1'h0;
        tick(4);
        check(32'(lock_bits), 32'(LOCK_RST));
        set_ptr(16'($random(seed)));
        r0 = (s == 1) ? {2'h3, bits, 4'hc} : {4'hf, bits, 2'h0};
        spm_r0 <= r0;
        store_program_op(OP_SETLOCK, 1'h0);
        spm_r0 <= 8'hff;
        store_program_op(OP_SETLOCK, 1'h0);
        tick(2);
        check(32'(lock_bits), 32'(r0[5:0]));
        set_ptr(((s == 1) ? 16'hf0c2 : 16'h1234) | 16'($random(seed) & 1));
        store_program_op(OP_FILL, 1'h0);
        store_program_op(OP_ERASE, !bits[0]);
        store_program_op(OP_WRITE, !bits[0]);
        cpu_pc <= oth;
        lpm(!bits[1]);
        cpu_pc <= own;
        lpm(1'h0);
        vectors_in_boot <= (s == 0);
        tick(3);
        check(32'(irq_block), 32'(!bits[1]));
        vectors_in_boot <= (s == 1);
        tick(3);
        check(32'(irq_block), 32'h0);
        cpu_pc <= 15'h7900;
        $display("test lock section %0d mode %0d done", s, k + 1);
      end
    end
    boot_reset_fuse <= 1'h0;
    arst_n <= 1'h0;
    tick(10);
    arst_n <= 1'h1;
    tick(5);
    check(32'(reset_vector), 32'(BOOT_START_WORD));
    axi_read(OFS_RVEC, d, r);
    check(d, 32'(BOOT_START_WORD));
    $display("test reset vector done");
    finish_test();
  end
endmodule : testbench
